// >>> rtl/dmp_params.svh
// register offsets, field positions, reset values and timing for the pin mux
`ifndef DMP_PARAMS_SVH
`define DMP_PARAMS_SVH

`define DMP_PIN1_IDX        7'h79
`define DMP_PIN4_IDX        7'h7C
`define DMP_CFG_IDX         7'h7D
`define DMP_STAT_IDX        7'h7E
`define DMP_PU_BIT          5
`define DMP_PD_BIT          4
`define DMP_MODE_BIT        7
`define DMP_PIN1_RESET      16'h0014
`define DMP_PIN4_RESET      16'h0000
`define DMP_CFG_RESET       16'h0001
`define DMP_DEB_TIME_US     100
`define DMP_CLK_MHZ         10
`define DMP_DEB_CYCLES      (`DMP_DEB_TIME_US * `DMP_CLK_MHZ)

`endif

// >>> rtl/dmp_pin_mux.sv
// dual multi-function pin mux with avalon-mm register slave
//
// Decided for this implementation: the Avalon-MM register port.
`timescale 1ns/1ns
`default_nettype none
`include "dmp_params.svh"

module dmp_pin_mux
  import dmp_pkg::*;
#(
  parameter int IRQ_W      = 8,
  parameter int DEB_CYCLES = `DMP_DEB_CYCLES
) (
  input  wire logic              clk_sys,
  input  wire logic              reset,
  input  wire logic [8:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic [31:0]            avs_readdata,
  output logic                   avs_waitrequest,
  input  wire logic [IRQ_W-1:0]  irq_sources,
  input  wire logic [IRQ_W-1:0]  irq_mask_n,
  input  wire logic              fll_lock,
  input  wire logic              fll_clk,
  input  wire logic              mic_bias_a_det,
  input  wire logic              mic_bias_a_short,
  input  wire logic              digital_mic_clk,
  input  wire logic              bclk_dir_master,
  input  wire logic              bclk_from_aif,
  input  wire logic              mclk_pin_in,
  input  wire logic              irq_multi_pin_in,
  output logic                   irq_multi_pin_out,
  output logic                   irq_multi_pin_oe,
  output logic                   pin1_pullup_en,
  output logic                   pin1_pulldown_en,
  input  wire logic              bitclk_multi_pin_in,
  output logic                   bitclk_multi_pin_out,
  output logic                   bitclk_multi_pin_oe,
  output logic                   audio_interface_bclk,
  output logic                   audio_interface_slave,
  output logic                   pin1_gp_input,
  output logic                   pin4_gp_input
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  dmp_state_s s;
  dmp_state_s n;

  function automatic logic [15:0] merge16(input logic [15:0] cur, input logic [31:0] wd,
                                          input logic [3:0] be);
    logic [15:0] r;
    r = cur;
    if (be[0]) begin
      r[7:0] = wd[7:0];
    end
    if (be[1]) begin
      r[15:8] = wd[15:8];
    end
    return r;
  endfunction

  // reserved codes and input leave the driver off
  function automatic dmp_drive_s pin_drive(input logic [3:0] sel, input logic opclk,
                                           input logic irq, input logic lock,
                                           input logic det, input logic shrt,
                                           input logic digital_mic, input logic fclk);
    dmp_drive_s d;
    d.oe  = 1'b1;
    d.out = 1'b0;
    unique case (sel)
      DMP_FN_OPCLK:   d.out = opclk;
      DMP_FN_LOW:     d.out = 1'b0;
      DMP_FN_HIGH:    d.out = 1'b1;
      DMP_FN_IRQ:     d.out = irq;
      DMP_FN_LOCK:    d.out = lock;
      DMP_FN_MICDET:  d.out = det;
      DMP_FN_MICSHRT: d.out = shrt;
      DMP_FN_DMICCLK: d.out = digital_mic;
      DMP_FN_FLLCLK:  d.out = fclk;
      default:        d.oe  = 1'b0;
    endcase
    return d;
  endfunction

  // debounce: accept a new level after it holds for the configured count
  function automatic logic [16:0] debounce(input logic en, input logic raw,
                                           input logic cur, input logic [15:0] cnt);
    logic [16:0] r;
    r = {cur, cnt};
    if (!en || raw == cur) begin
      r = {raw, 16'h0000};
    end else if (cnt >= 16'(DEB_CYCLES - 1)) begin
      r = {raw, 16'h0000};
    end else begin
      r = {cur, cnt + 16'h0001};
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic        p4_gp_mode;
  logic [15:0] rd16;
  logic [16:0] d1;
  logic [16:0] d4;

  always_comb begin
    n = s;
    p4_gp_mode = s.pin4_control[`DMP_MODE_BIT] && !bclk_dir_master;
    rd16 = 16'h0000;
    unique case (avs_address[8:2])
      `DMP_PIN1_IDX: rd16 = s.pin1_control;
      `DMP_PIN4_IDX: rd16 = s.pin4_control;
      `DMP_CFG_IDX:  rd16 = s.cfg;
      `DMP_STAT_IDX: rd16 = {12'h000, s.irq, p4_gp_mode, s.p4_in, s.p1_in};
      default:       rd16 = 16'h0000;
    endcase
    n.bus = DMP_BUS_IDLE;
    if ((avs_read || avs_write) && s.bus == DMP_BUS_IDLE) begin
      n.bus = DMP_BUS_ACK;
      n.readdata = {16'h0000, rd16};
      if (avs_write) begin
        unique case (avs_address[8:2])
          `DMP_PIN1_IDX: n.pin1_control = merge16(s.pin1_control, avs_writedata,
                                                  avs_byteenable) & 16'h003F;
          `DMP_PIN4_IDX: n.pin4_control = merge16(s.pin4_control, avs_writedata,
                                                  avs_byteenable) & 16'h008F;
          `DMP_CFG_IDX:  n.cfg = merge16(s.cfg, avs_writedata, avs_byteenable) & 16'h0FFF;
          default:       n.readdata = 32'h0000_0000;
        endcase
      end
    end
    n.irq = |(irq_sources & irq_mask_n);
    if (s.div_cnt >= s.cfg[11:1]) begin
      n.div_cnt = 12'h000;
      n.opclk = !s.opclk;
    end else begin
      n.div_cnt = s.div_cnt + 12'h001;
    end
    d1 = debounce(s.cfg[0], irq_multi_pin_in, s.p1_in, s.p1_deb_cnt);
    d4 = debounce(s.cfg[0], bitclk_multi_pin_in, s.p4_in, s.p4_deb_cnt);
    {n.p1_in, n.p1_deb_cnt} = d1;
    {n.p4_in, n.p4_deb_cnt} = d4;
    n.p1 = pin_drive(s.pin1_control[3:0], s.opclk, s.irq, fll_lock, mic_bias_a_det,
                     mic_bias_a_short, digital_mic_clk, fll_clk);
    n.p1_pu = s.pin1_control[`DMP_PU_BIT];
    n.p1_pd = s.pin1_control[`DMP_PD_BIT];
    if (p4_gp_mode) begin
      n.p4 = pin_drive(s.pin4_control[3:0], s.opclk, s.irq, fll_lock, mic_bias_a_det,
                       mic_bias_a_short, digital_mic_clk, fll_clk);
      n.aif_bclk  = mclk_pin_in;
      n.aif_slave = 1'b1;
    end else begin
      n.p4.oe     = bclk_dir_master;
      n.p4.out    = bclk_from_aif;
      n.aif_bclk  = bclk_dir_master ? bclk_from_aif : bitclk_multi_pin_in;
      n.aif_slave = !bclk_dir_master;
    end
    if (reset) begin
      n = '0;
      n.pin1_control = `DMP_PIN1_RESET;
      n.pin4_control = `DMP_PIN4_RESET;
      n.cfg = `DMP_CFG_RESET;
      n.p1.oe = 1'b1;
      n.p1_pd = 1'b1;
      n.aif_slave = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    s <= n;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign avs_readdata          = s.readdata;
  assign avs_waitrequest       = !(s.bus == DMP_BUS_ACK);
  assign irq_multi_pin_out     = s.p1.out;
  assign irq_multi_pin_oe      = s.p1.oe;
  assign pin1_pullup_en        = s.p1_pu;
  assign pin1_pulldown_en      = s.p1_pd;
  assign bitclk_multi_pin_out  = s.p4.out;
  assign bitclk_multi_pin_oe   = s.p4.oe;
  assign audio_interface_bclk  = s.aif_bclk;
  assign audio_interface_slave = s.aif_slave;
  assign pin1_gp_input         = s.p1_in;
  assign pin4_gp_input         = s.p4_in;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence seq_reset_rel;
    $fell(reset);
  endsequence

  AST_RESET_IRQ_PIN: assert property (@(posedge clk_sys)
    seq_reset_rel |-> s.pin1_control[3:0] == DMP_FN_IRQ && irq_multi_pin_oe && pin1_pulldown_en
                      && !pin1_pullup_en)
    else $error("pin one not irq with pull-down after reset");

  AST_PULLUP: assert property (@(posedge clk_sys) disable iff (reset)
    ##1 pin1_pullup_en == $past(s.pin1_control[5]))
    else $error("pull-up does not follow bit 5");

  AST_PULLDOWN: assert property (@(posedge clk_sys) disable iff (reset)
    ##1 pin1_pulldown_en == $past(s.pin1_control[4]))
    else $error("pull-down does not follow bit 4");

  AST_CONST_LEVEL: assert property (@(posedge clk_sys) disable iff (reset)
    s.pin1_control[3:0] == DMP_FN_HIGH ##1 s.pin1_control[3:0] == DMP_FN_HIGH
      |-> irq_multi_pin_oe && irq_multi_pin_out)
    else $error("pin one not high for code 0011");

  AST_IRQ_ROUTE: assert property (@(posedge clk_sys) disable iff (reset)
    s.pin1_control[3:0] == DMP_FN_IRQ ##1 s.pin1_control[3:0] == DMP_FN_IRQ
      |-> irq_multi_pin_out == $past(s.irq))
    else $error("irq not routed to pin one");

  AST_IRQ_OR: assert property (@(posedge clk_sys) disable iff (reset)
    ##1 s.irq == $past(|(irq_sources & irq_mask_n)))
    else $error("irq is not or of unmasked inputs");

  AST_GP_SLAVE: assert property (@(posedge clk_sys) disable iff (reset)
    (s.pin4_control[7] && !bclk_dir_master) |=> audio_interface_slave
      && audio_interface_bclk == $past(mclk_pin_in))
    else $error("bit clock not from master clock in general mode");

  AST_BCLK_DEFAULT: assert property (@(posedge clk_sys) disable iff (reset)
    !s.pin4_control[7] |=> bitclk_multi_pin_oe == $past(bclk_dir_master))
    else $error("bit clock direction wrong");

  AST_RESERVED: assert property (@(posedge clk_sys) disable iff (reset)
    s.pin1_control[3:0] >= 4'hA ##1 s.pin1_control[3:0] >= 4'hA |-> !irq_multi_pin_oe)
    else $error("reserved code drives pin one");

  AST_WAIT_ONE: assert property (@(posedge clk_sys) disable iff (reset)
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer not after one cycle");

  sequence seq_p1_sel(logic [3:0] code);
    s.pin1_control[3:0] == code;
  endsequence

  sequence seq_p4_gp_sel(logic [3:0] code);
    s.pin4_control[`DMP_MODE_BIT] && !bclk_dir_master && s.pin4_control[3:0] == code;
  endsequence

  sequence seq_opclk_fast;
    s.pin1_control[3:0] == DMP_FN_OPCLK && s.cfg[11:1] == 11'h000;
  endsequence

  AST_CONST_LOW: assert property (@(posedge clk_sys) disable iff (reset)
    seq_p1_sel(DMP_FN_LOW) ##1 seq_p1_sel(DMP_FN_LOW)
      |-> irq_multi_pin_oe && !irq_multi_pin_out)
    else $error("pin one not low for code 0010");

  AST_INPUT_OFF: assert property (@(posedge clk_sys) disable iff (reset)
    seq_p1_sel(DMP_FN_INPUT) ##1 seq_p1_sel(DMP_FN_INPUT)
      |-> !irq_multi_pin_oe)
    else $error("pin one driven while input");

  AST_LOCK_ROUTE: assert property (@(posedge clk_sys) disable iff (reset)
    seq_p1_sel(DMP_FN_LOCK) ##1 seq_p1_sel(DMP_FN_LOCK)
      |-> irq_multi_pin_oe && irq_multi_pin_out == $past(fll_lock))
    else $error("lock not routed to pin one");

  AST_MICDET_ROUTE: assert property (@(posedge clk_sys) disable iff (reset)
    seq_p1_sel(DMP_FN_MICDET) ##1 seq_p1_sel(DMP_FN_MICDET)
      |-> irq_multi_pin_out == $past(mic_bias_a_det))
    else $error("mic detect not routed to pin one");

  AST_MICSHRT_ROUTE: assert property (@(posedge clk_sys) disable iff (reset)
    seq_p1_sel(DMP_FN_MICSHRT) ##1 seq_p1_sel(DMP_FN_MICSHRT)
      |-> irq_multi_pin_out == $past(mic_bias_a_short))
    else $error("mic short not routed to pin one");

  AST_DIGITAL_MIC_ROUTE: assert property (@(posedge clk_sys) disable iff (reset)
    seq_p1_sel(DMP_FN_DMICCLK) ##1 seq_p1_sel(DMP_FN_DMICCLK)
      |-> irq_multi_pin_out == $past(digital_mic_clk))
    else $error("mic clock not routed to pin one");

  AST_FLLCLK_ROUTE: assert property (@(posedge clk_sys) disable iff (reset)
    seq_p1_sel(DMP_FN_FLLCLK) ##1 seq_p1_sel(DMP_FN_FLLCLK)
      |-> irq_multi_pin_out == $past(fll_clk))
    else $error("loop clock not routed to pin one");

  AST_OPCLK_TOGGLE: assert property (@(posedge clk_sys) disable iff (reset)
    seq_opclk_fast [*3]
      |-> $changed(irq_multi_pin_out))
    else $error("divided clock not toggling on pin one");

  AST_P4_HIGH: assert property (@(posedge clk_sys) disable iff (reset)
    seq_p4_gp_sel(DMP_FN_HIGH) ##1 seq_p4_gp_sel(DMP_FN_HIGH)
      |-> bitclk_multi_pin_oe && bitclk_multi_pin_out)
    else $error("pin two not high for code 0011");

  AST_P4_IRQ: assert property (@(posedge clk_sys) disable iff (reset)
    seq_p4_gp_sel(DMP_FN_IRQ) ##1 seq_p4_gp_sel(DMP_FN_IRQ)
      |-> bitclk_multi_pin_out == $past(s.irq))
    else $error("irq not routed to pin two");

  AST_P4_INPUT: assert property (@(posedge clk_sys) disable iff (reset)
    seq_p4_gp_sel(DMP_FN_INPUT)
      |=> !bitclk_multi_pin_oe)
    else $error("pin two driven while input");

  AST_P4_RESERVED: assert property (@(posedge clk_sys) disable iff (reset)
    s.pin4_control[7] && !bclk_dir_master && s.pin4_control[3:0] >= 4'hA
      |=> !bitclk_multi_pin_oe)
    else $error("reserved code drives pin two");

  AST_MASTER_KEEPS_BCLK: assert property (@(posedge clk_sys) disable iff (reset)
    s.pin4_control[7] && bclk_dir_master
      |=> !audio_interface_slave && bitclk_multi_pin_oe)
    else $error("mode bit took pin two while master");

  AST_DEB_P1: assert property (@(posedge clk_sys) disable iff (reset)
    $changed(pin1_gp_input) && $past(s.cfg[0])
      |-> $past(s.p1_deb_cnt) == 16'(DEB_CYCLES - 1))
    else $error("pin one input changed before debounce time");

  AST_DEB_P4: assert property (@(posedge clk_sys) disable iff (reset)
    $changed(pin4_gp_input) && $past(s.cfg[0])
      |-> $past(s.p4_deb_cnt) == 16'(DEB_CYCLES - 1))
    else $error("pin two input changed before debounce time");

  AST_READ_UPPER_ZERO: assert property (@(posedge clk_sys) disable iff (reset)
    !avs_waitrequest
      |-> avs_readdata[31:16] == 16'h0000)
    else $error("upper read half not zero");

endmodule
`default_nettype wire

// >>> rtl/dmp_pkg.sv
// types for the dual multi-function pin mux
package dmp_pkg;

  typedef enum logic [3:0] {
    DMP_FN_INPUT   = 4'h0,
    DMP_FN_OPCLK   = 4'h1,
    DMP_FN_LOW     = 4'h2,
    DMP_FN_HIGH    = 4'h3,
    DMP_FN_IRQ     = 4'h4,
    DMP_FN_LOCK    = 4'h5,
    DMP_FN_MICDET  = 4'h6,
    DMP_FN_MICSHRT = 4'h7,
    DMP_FN_DMICCLK = 4'h8,
    DMP_FN_FLLCLK  = 4'h9
  } dmp_func_e;

  typedef enum logic [1:0] {
    DMP_BUS_IDLE = 2'b00,
    DMP_BUS_ACK  = 2'b01
  } dmp_bus_e;

  typedef struct packed {
    logic        oe;
    logic        out;
  } dmp_drive_s;

  typedef struct packed {
    logic [15:0] pin1_control;
    logic [15:0] pin4_control;
    logic [15:0] cfg;
    dmp_bus_e    bus;
    logic [31:0] readdata;
    dmp_drive_s  p1;
    dmp_drive_s  p4;
    logic        p1_pu;
    logic        p1_pd;
    logic        aif_bclk;
    logic        aif_slave;
    logic        irq;
    logic [11:0] div_cnt;
    logic        opclk;
    logic        p1_in;
    logic        p4_in;
    logic [15:0] p1_deb_cnt;
    logic [15:0] p4_deb_cnt;
  } dmp_state_s;

endpackage

// >>> verification/dmp_board_model.sv
// board-side model of the two multi-function pads
`timescale 1ns/1ns
`default_nettype none
module dmp_board_model (
  input  wire logic clk_sys,
  input  wire logic p1_out,
  input  wire logic p1_oe,
  input  wire logic pu,
  input  wire logic pd,
  input  wire logic p4_out,
  input  wire logic p4_oe,
  input  wire logic ext_en,
  input  wire logic ext_val,
  output logic      p1_pad,
  output logic      p4_pad
);
  logic tog = 1'b0;
  // -------------------------------------------------
  // undriven pad with no pull and no external level shows a changing level, not a hold
  // -------------------------------------------------
  always @(posedge clk_sys) tog <= ~tog;
  always_comb begin
    if (p1_oe) p1_pad = p1_out;
    else if (ext_en) p1_pad = ext_val;
    else if (pu) p1_pad = 1'b1;
    else if (pd) p1_pad = 1'b0;
    else p1_pad = tog;
    p4_pad = p4_oe ? p4_out : (ext_en ? ext_val : tog);
  end
endmodule
`default_nettype wire

// >>> verification/test_dual_multifunction_pin_mux.sv
// self-checking bench for the pin mux
`timescale 1ns/1ns
`default_nettype none
module test_dual_multifunction_pin_mux;
  import dmp_pkg::*;
  logic        clk_sys = 1'b0;
  logic        reset = 1'b1;
  logic [8:0]  adr = '0;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wd = '0;
  logic [7:0]  src = '0;
  logic [7:0]  msk = '0;
  logic        lock = 0, fclk = 0, det = 0, shrt = 0, digital_mic = 0;
  logic        dir_m = 0, baif = 0, mclk = 0, ext_en = 0, ext_val = 0;
  logic [31:0] rdata;
  logic        wreq, p1o, p1e, pu, pd, p4o, p4e, abclk, aslv, g1, g4, p1pad, p4pad;
  logic        eo, ev;
  logic [31:0] expq[$];
  int          error_cnt = 0;
  int          samples_checked = 0;
  always #50 clk_sys = ~clk_sys;
  dmp_pin_mux #(.DEB_CYCLES(4)) dut (.clk_sys(clk_sys), .reset(reset), .avs_address(adr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_byteenable(4'h3),
    .avs_readdata(rdata), .avs_waitrequest(wreq), .irq_sources(src), .irq_mask_n(msk),
    .fll_lock(lock), .fll_clk(fclk), .mic_bias_a_det(det), .mic_bias_a_short(shrt),
    .digital_mic_clk(digital_mic), .bclk_dir_master(dir_m), .bclk_from_aif(baif),
    .mclk_pin_in(mclk), .irq_multi_pin_in(p1pad), .irq_multi_pin_out(p1o),
    .irq_multi_pin_oe(p1e), .pin1_pullup_en(pu), .pin1_pulldown_en(pd),
    .bitclk_multi_pin_in(p4pad), .bitclk_multi_pin_out(p4o), .bitclk_multi_pin_oe(p4e),
    .audio_interface_bclk(abclk), .audio_interface_slave(aslv), .pin1_gp_input(g1),
    .pin4_gp_input(g4));
  dmp_board_model board (.clk_sys(clk_sys), .p1_out(p1o), .p1_oe(p1e), .pu(pu), .pd(pd),
    .p4_out(p4o), .p4_oe(p4e), .ext_en(ext_en), .ext_val(ext_val), .p1_pad(p1pad),
    .p4_pad(p4pad));
  // -------------------------------------------------
  // checking and bus tasks
  // -------------------------------------------------
  task automatic wrap_up();
    if (error_cnt == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [8:0] a, input logic [31:0] d,
                     input logic [31:0] e);
    int n;
    n = 0;
    @(posedge clk_sys);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    if (!w) expq.push_back(e);
    do begin
      @(posedge clk_sys);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    if (n >= 50) begin
      error_cnt++;
      wrap_up();
    end
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  always @(posedge clk_sys) begin
    if (rd && wreq === 1'b0 && expq.size() > 0) chk("readdata", rdata, expq.pop_front());
  end
  initial begin
    #(100 * 50000);
    error_cnt++;
    wrap_up();
  end
  // -------------------------------------------------
  // scenarios
  // -------------------------------------------------
  initial begin
    void'($urandom(32'h6aaf));
    cyc(5);
    reset <= 1'b0;
    chk("p1_oe", p1e, 1);
    chk("pulldown", pd, 1);
    chk("pullup", pu, 0);
    bus(0, 9'h1E4, 0, 32'h0000_0014);
    bus(0, 9'h1F0, 0, 32'h0000_0000);
    bus(0, 9'h100, 0, 32'h0000_0000);
    bus(0, 9'h1F4, 0, 32'h0000_0001);
    bus(1, 9'h1E4, 32'h0000_0020, 0);
    bus(0, 9'h1E4, 0, 32'h0000_0020);
    cyc(3);
    chk("pullup", pu, 1);
    chk("pulldown", pd, 0);
    dir_m <= 1'b1;
    baif <= $urandom;
    cyc(3);
    chk("p4_oe", p4e, 1);
    chk("p4_out", p4o, baif);
    dir_m <= 1'b0;
    ext_en <= 1'b1;
    ext_val <= $urandom;
    cyc(3);
    chk("p4_oe", p4e, 0);
    chk("aif_bclk", abclk, ext_val);
    chk("aif_slave", aslv, 1);
    bus(1, 9'h1F0, 32'h0000_0080, 0);
    mclk <= $urandom;
    cyc(3);
    chk("aif_bclk", abclk, mclk);
    chk("aif_slave", aslv, 1);
    dir_m <= 1'b1;
    cyc(3);
    chk("aif_slave", aslv, 0);
    chk("p4_oe", p4e, 1);
    dir_m <= 1'b0;
    for (int k = 0; k < 16; k++) begin
      {src, msk, lock, det, shrt, digital_mic, fclk} <= $urandom;
      bus(1, 9'h1E4, k, 0);
      bus(1, 9'h1F0, 32'h0000_0080 | k, 0);
      bus(0, 9'h1F0, 0, 32'h0000_0080 | k);
      cyc(3);
      eo = (k >= 1 && k <= 9);
      case (k)
        3: ev = 1'b1;
        4: ev = |(src & msk);
        5: ev = lock;
        6: ev = det;
        7: ev = shrt;
        8: ev = digital_mic;
        9: ev = fclk;
        default: ev = 1'b0;
      endcase
      chk("p1_oe", p1e, eo);
      chk("p4_oe", p4e, eo);
      if (k >= 2 && k <= 9) chk("p1_out", p1o, ev);
      if (k >= 2 && k <= 9) chk("p4_out", p4o, ev);
      if (k == 1) begin
        ev = p1o;
        cyc(1);
        chk("opclk", p1o, !ev);
      end
    end
    bus(1, 9'h1E4, 0, 0);
    bus(1, 9'h1F0, 32'h0000_0080, 0);
    for (int v = 0; v < 2; v++) begin
      ext_val <= v[0];
      cyc(20);
      chk("pin1_in", g1, v[0]);
      chk("pin4_in", g4, v[0]);
    end
    ext_val <= 1'b0;
    cyc(2);
    ext_val <= 1'b1;
    cyc(10);
    chk("pin1_in", g1, 1);
    chk("pin4_in", g4, 1);
    bus(0, 9'h1F8, 0, {28'h000_0000, |(src & msk), 3'b111});
    reset <= 1'b1;
    cyc(2);
    reset <= 1'b0;
    chk("p1_oe", p1e, 1);
    chk("pulldown", pd, 1);
    bus(0, 9'h1E4, 0, 32'h0000_0014);
    bus(0, 9'h1F0, 0, 32'h0000_0000);
    wrap_up();
  end
endmodule
`default_nettype wire
